// ==== scdc_device.sv ====
// scan cycle down counter with its parallel port byte access
module scdc_device
    import scdc_pkg::*;
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    // parallel host port
    scdc_link_if.dev              link,
    // external reset pin, asynchronous
    input  wire logic             rstPinN,
    // scan control from mode registers and test clock control
    input  wire logic             countEn,
    input  wire logic             singleStepBit,
    input  wire logic             tckPulse,
    // to shifter/buffers and test clock control
    output logic                  termCount,
    output logic                  tckGate,
    output logic [CNT_W-1:0]      countValue
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [SEL_W-1:0] loadIdx;
    logic [SEL_W-1:0] next_loadIdx;
    logic [SEL_W-1:0] readIdx;
    logic [SEL_W-1:0] next_readIdx;
    logic             stepDone;
    logic             next_stepDone;
    logic [SEG_W-1:0] rdData;
    logic [SEG_W-1:0] next_rdData;
    logic             rdy;
    logic             next_rdy;
    logic             next_termCount;
    logic             pinSync1;
    logic             pinSync2;
    logic             cntHit;
    logic             runDec;
    logic             stepDec;
    logic             doDec;

    // reset pin synchroniser
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pinSync1 <= 1'b1;
            pinSync2 <= 1'b1;
        end else begin
            pinSync1 <= rstPinN;
            pinSync2 <= pinSync1;
        end
    end

    always_comb begin
        cntHit  = (link.addr == CNT_ADDR);
        // normal counting on each issued test clock
        runDec  = countEn & ~singleStepBit & tckPulse;
        // one decrement per setting of the step bit
        stepDec = singleStepBit & ~stepDone;
        // zero never decrements
        doDec   = (runDec | stepDec) & (count != CNT_RESET);

        next_count     = count;
        next_loadIdx   = loadIdx;
        next_readIdx   = readIdx;
        next_rdData    = rdData;
        next_rdy       = 1'b0;
        next_termCount = 1'b0;
        next_stepDone  = singleStepBit & (stepDone | stepDec);

        if (doDec) begin
            next_count = count - 32'h00000001;
            if (count == 32'h00000001 && countEn) begin
                // terminal count ends shift and swaps buffers
                next_termCount = 1'b1;
                next_count     = CNT_RESET;
            end
        end

        if (link.wrStb) begin
            next_rdy     = 1'b1;
            next_readIdx = '0;
            if (cntHit) begin
                // load wins over decrement, enabled or not
                next_count     = count;
                next_termCount = 1'b0;
                next_count[loadIdx*SEG_W +: SEG_W] = link.wrData;
                next_loadIdx = loadIdx + 2'h1;
            end else begin
                next_loadIdx = '0;
            end
        end else if (link.rdStb) begin
            next_rdy = 1'b1;
            if (cntHit) begin
                // live segment, no hold latch
                next_rdData  = count[readIdx*SEG_W +: SEG_W];
                next_readIdx = readIdx + 2'h1;
            end else begin
                next_rdData  = '0;
                next_readIdx = '0;
            end
        end

        // only the pin clears; the sync reset bit is not wired here
        if (!pinSync2) begin
            next_count     = CNT_RESET;
            next_loadIdx   = '0;
            next_readIdx   = '0;
            next_termCount = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            count     <= CNT_RESET;
            loadIdx   <= '0;
            readIdx   <= '0;
            stepDone  <= 1'b0;
            rdData    <= '0;
            rdy       <= 1'b0;
            termCount <= 1'b0;
        end else begin
            count     <= next_count;
            loadIdx   <= next_loadIdx;
            readIdx   <= next_readIdx;
            stepDone  <= next_stepDone;
            rdData    <= next_rdData;
            rdy       <= next_rdy;
            termCount <= next_termCount;
        end
    end

    // test clock held in single step and at zero
    assign tckGate     = countEn & ~singleStepBit & (count != CNT_RESET);
    assign countValue  = count;
    assign link.rdData = rdData;
    assign link.rdy    = rdy;

endmodule

// ==== scdc_host.sv ====
// host end: avalon slave registers driving byte loads and reads
module scdc_host
    import scdc_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    // avalon-mm slave
    input  wire logic [AVS_AW-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [CNT_W-1:0]  avs_writedata,
    output logic [CNT_W-1:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // interrupt
    output logic                   irq,
    // parallel host port
    scdc_link_if.host              link
);

    typedef enum {H_IDLE, H_WR, H_WR_WAIT, H_RD, H_RD_WAIT} scdc_hstate_t;

    scdc_hstate_t     state;
    scdc_hstate_t     next_state;
    logic [CNT_W-1:0] loadData;
    logic [CNT_W-1:0] next_loadData;
    logic [CNT_W-1:0] readData;
    logic [CNT_W-1:0] next_readData;
    logic [SEL_W-1:0] byteIdx;
    logic [SEL_W-1:0] next_byteIdx;
    logic [SEG_W-1:0] wrData;
    logic [SEG_W-1:0] next_wrData;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] next_irqStatus;
    logic [IRQ_W-1:0] irqMask;
    logic [IRQ_W-1:0] next_irqMask;
    logic [IRQ_W-1:0] irqSet;
    logic             ack;
    logic             next_ack;
    logic [CNT_W-1:0] next_readdata;
    logic             busWr;
    logic             busy;

    always_comb begin
        busy          = (state != H_IDLE);
        busWr         = avs_write & ack;
        next_ack      = (avs_read | avs_write) & ~ack;
        next_readdata = avs_readdata;
        if (avs_read && !ack) begin
            case (avs_address)
                OFS_LOAD:   next_readdata = loadData;
                OFS_READ:   next_readdata = readData;
                OFS_STATUS: next_readdata = {31'h00000000, busy};
                OFS_IRQ:    next_readdata = {30'h00000000, irqStatus};
                OFS_MASK:   next_readdata = {30'h00000000, irqMask};
                default:    next_readdata = '0;
            endcase
        end

        next_state    = state;
        next_loadData = loadData;
        next_readData = readData;
        next_byteIdx  = byteIdx;
        next_wrData   = wrData;
        next_irqMask  = irqMask;
        irqSet        = '0;

        if (busWr && avs_address == OFS_LOAD && !busy) begin
            next_loadData = avs_writedata;
        end
        if (busWr && avs_address == OFS_MASK) begin
            next_irqMask = avs_writedata[IRQ_W-1:0];
        end

        case (state)
            H_IDLE: begin
                next_byteIdx = '0;
                if (busWr && avs_address == OFS_CMD) begin
                    if (avs_writedata[CMD_LOAD]) begin
                        // lowest byte goes first
                        next_wrData = loadData[SEG_W-1:0];
                        next_state  = H_WR;
                    end else if (avs_writedata[CMD_READ]) begin
                        next_state = H_RD;
                    end
                end
            end
            H_WR: next_state = H_WR_WAIT;
            H_WR_WAIT: begin
                if (link.rdy) begin
                    // four counter writes back to back, nothing between
                    next_byteIdx = byteIdx + 2'h1;
                    next_wrData  = loadData[SEL_W'(byteIdx + 2'h1)*SEG_W +: SEG_W];
                    if (byteIdx == LAST_SEG) begin
                        irqSet[IRQ_LOAD] = 1'b1;
                        next_state       = H_IDLE;
                    end else begin
                        next_state = H_WR;
                    end
                end
            end
            H_RD: next_state = H_RD_WAIT;
            H_RD_WAIT: begin
                if (link.rdy) begin
                    next_readData[byteIdx*SEG_W +: SEG_W] = link.rdData;
                    next_byteIdx = byteIdx + 2'h1;
                    if (byteIdx == LAST_SEG) begin
                        irqSet[IRQ_READ] = 1'b1;
                        next_state       = H_IDLE;
                    end else begin
                        next_state = H_RD;
                    end
                end
            end
            default: next_state = H_IDLE;
        endcase

        // set wins over write-one-to-clear
        next_irqStatus = irqStatus;
        if (busWr && avs_address == OFS_IRQ) begin
            next_irqStatus = irqStatus & ~avs_writedata[IRQ_W-1:0];
        end
        next_irqStatus = next_irqStatus | irqSet;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state        <= H_IDLE;
            loadData     <= CNT_RESET;
            readData     <= CNT_RESET;
            byteIdx      <= '0;
            wrData       <= '0;
            irqStatus    <= '0;
            irqMask      <= MASK_RESET;
            ack          <= 1'b0;
            avs_readdata <= '0;
        end else begin
            state        <= next_state;
            loadData     <= next_loadData;
            readData     <= next_readData;
            byteIdx      <= next_byteIdx;
            wrData       <= next_wrData;
            irqStatus    <= next_irqStatus;
            irqMask      <= next_irqMask;
            ack          <= next_ack;
            avs_readdata <= next_readdata;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign irq             = |(irqStatus & irqMask);
    assign link.wrStb      = (state == H_WR);
    assign link.rdStb      = (state == H_RD);
    assign link.addr       = CNT_ADDR;
    assign link.wrData     = wrData;

endmodule

// ==== scdc_link_if.sv ====
// byte-wide parallel host port between host end and counter device
interface scdc_link_if;
    import scdc_pkg::*;
    logic              wrStb;
    logic              rdStb;
    logic [ADDR_W-1:0] addr;
    logic [SEG_W-1:0]  wrData;
    logic [SEG_W-1:0]  rdData;
    logic              rdy;

    modport dev (
        input  wrStb,
        input  rdStb,
        input  addr,
        input  wrData,
        output rdData,
        output rdy
    );

    modport host (
        output wrStb,
        output rdStb,
        output addr,
        output wrData,
        input  rdData,
        input  rdy
    );
endinterface

// ==== scdc_pkg.sv ====
// constants shared by the scan cycle counter device and its host end
// Operation
// - 32-bit down counter from four byte segments
// - loads accepted whether enabled or not
// - four counter writes, lowest byte first
// - foreign write restarts load byte sequencing
// - terminal count or reset pin clears counter
// - sync reset bit leaves counter untouched
// - all four bytes readable directly, no latch
// - single step: one decrement, test clock held
// - zero count stays zero, never wraps
// - host loads nonzero count before single step; the bench also loads zero and steps it
// - terminal count ends shift, swaps buffer register
package scdc_pkg;
    localparam int CNT_W   = 32;
    localparam int SEG_W   = 8;
    localparam int SEGS    = CNT_W / SEG_W;
    localparam int SEL_W   = 2;
    localparam int ADDR_W  = 3;
    localparam logic [ADDR_W-1:0] CNT_ADDR = 3'h0;
    localparam logic [SEL_W-1:0]  LAST_SEG = 2'h3;
    // host register byte offsets
    localparam int AVS_AW = 5;
    localparam logic [AVS_AW-1:0] OFS_LOAD   = 5'h00;
    localparam logic [AVS_AW-1:0] OFS_CMD    = 5'h04;
    localparam logic [AVS_AW-1:0] OFS_READ   = 5'h08;
    localparam logic [AVS_AW-1:0] OFS_STATUS = 5'h0c;
    localparam logic [AVS_AW-1:0] OFS_IRQ    = 5'h10;
    localparam logic [AVS_AW-1:0] OFS_MASK   = 5'h14;
    // field positions
    localparam int CMD_LOAD  = 0;
    localparam int CMD_READ  = 1;
    localparam int IRQ_LOAD  = 0;
    localparam int IRQ_READ  = 1;
    localparam int IRQ_W     = 2;
    localparam int STAT_BUSY = 0;
    // reset values
    localparam logic [CNT_W-1:0]  CNT_RESET = 32'h00000000;
    localparam logic [IRQ_W-1:0]  MASK_RESET = 2'h0;
endpackage

// ==== scdc_properties.sv ====
// checker for the byte link and the scan cycle counter outputs
module scdc_properties
    import scdc_pkg::*;
(
    // clock and reset
    input wire logic             ref_clk,
    input wire logic             nrst,
    // link
    input wire logic             wrStb,
    input wire logic             rdStb,
    input wire logic             rdy,
    // counter
    input wire logic             rstPinN,
    input wire logic             countEn,
    input wire logic             singleStepBit,
    input wire logic             tckPulse,
    input wire logic             termCount,
    input wire logic             tckGate,
    input wire logic [CNT_W-1:0] countValue
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic dec;
    assign dec = tckPulse && countEn && !singleStepBit && !wrStb;

    AST_RDY_ANSWER: assert property ((wrStb || rdStb) |=> rdy)
        else $error("no rdy after strobe");
    AST_RDY_CAUSE: assert property (rdy |-> $past(wrStb || rdStb))
        else $error("rdy without strobe");
    AST_NO_WRAP: assert property (countValue == 32'h0 && !wrStb |=> countValue == 32'h0)
        else $error("zero count changed");
    AST_DEC_ONE: assert property (dec && countValue > 32'h1 |=> countValue == $past(countValue) - 32'h1)
        else $error("bad decrement");
    AST_TC_HIT: assert property (dec && countValue == 32'h1 |=> termCount && countValue == 32'h0)
        else $error("terminal count missed");
    AST_TC_PULSE: assert property (termCount |=> !termCount)
        else $error("terminal count too long");
    AST_TC_CAUSE: assert property (termCount |-> countValue == 32'h0 && $past(countValue) == 32'h1)
        else $error("stray terminal count");
    AST_GATE: assert property (tckGate == (countEn && !singleStepBit && countValue != 32'h0))
        else $error("bad test clock gate");
    AST_STEP_HELD: assert property (singleStepBit && $past(singleStepBit) && !wrStb |=> $stable(countValue))
        else $error("second step decrement");
    AST_PIN_CLR: assert property (!rstPinN [*3] |=> countValue == 32'h0)
        else $error("reset pin left count");

    cover property (termCount);
    cover property (singleStepBit && !$past(singleStepBit));
    cover property (rdStb ##1 rdy);
endmodule

// ==== scdc_tb.sv ====
// end to end bench: host end and counter device joined by the link
module tb
    import scdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              ref_clk, nrst, avs_read, avs_write, avs_waitrequest, irq;
    logic              rstPinN, countEn, singleStepBit, tckPulse, termCount, tckGate;
    logic [AVS_AW-1:0] avs_address;
    logic [CNT_W-1:0]  avs_writedata, avs_readdata, countValue, q;
    int                err_total, samples_checked, cyc, tcs;
    // rows: value loaded, value expected back
    logic [63:0]       rows [4] = '{64'h01000000_01000000, 64'h000000ff_000000ff,
                                    64'hffffffff_ffffffff, 64'h12345678_12345678};

    scdc_link_if link ();
    scdc_host scdc_host_inst (.ref_clk, .nrst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .link(link.host));
    scdc_device scdc_device_inst (.ref_clk, .nrst, .link(link.dev), .rstPinN, .countEn,
        .singleStepBit, .tckPulse, .termCount, .tckGate, .countValue);
    scdc_properties scdc_properties_inst (.ref_clk, .nrst, .wrStb(link.wrStb),
        .rdStb(link.rdStb), .rdy(link.rdy), .rstPinN, .countEn, .singleStepBit,
        .tckPulse, .termCount, .tckGate, .countValue);

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (termCount === 1'b1)
            tcs <= tcs + 1;
        if (cyc == 5000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic chk32(input string n, input logic [CNT_W-1:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk1(input string n, input logic e, g);
        chk32(n, {31'h0, e}, {31'h0, g});
    endtask

    // request held until waitrequest sampled low; only the cycle ceiling ends a hang
    task automatic av(input logic w, input logic [AVS_AW-1:0] a, input logic [CNT_W-1:0] d);
        @(posedge ref_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // poll busy until the link sequence is over
    task automatic idle();
        do begin
            av(1'b0, OFS_STATUS, 32'h0);
        end while (q[STAT_BUSY] !== 1'b0);
    endtask

    task automatic load(input logic [CNT_W-1:0] v);
        av(1'b1, OFS_LOAD, v);
        av(1'b1, OFS_CMD, 32'h1);
        idle();
    endtask

    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {countEn, singleStepBit, tckPulse, err_total, samples_checked, cyc, tcs} = '0;
        rstPinN = 1'b1;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        chk32("count after reset", CNT_RESET, countValue);
        foreach (rows[i]) begin
            load(rows[i][63:32]);
            chk32("count", rows[i][31:0], countValue);
            av(1'b1, OFS_CMD, 32'h2);
            idle();
            av(1'b0, OFS_READ, 32'h0);
            chk32("readback", rows[i][31:0], q);
        end
        chk1("irq masked", 1'b0, irq);
        av(1'b1, OFS_MASK, 32'h3);
        // irq settles after the edge that takes the write
        @(negedge ref_clk);
        chk1("irq raised", 1'b1, irq);
        av(1'b1, OFS_IRQ, 32'h3);
        @(negedge ref_clk);
        chk1("irq cleared", 1'b0, irq);
        av(1'b0, 5'h1c, 32'h0);
        chk32("unmapped", 32'h0, q);
        countEn <= 1'b1;
        load(32'h3);
        chk32("load while enabled", 32'h3, countValue);
        repeat (4) begin
            @(posedge ref_clk);
            tckPulse <= 1'b1;
            @(posedge ref_clk);
            tckPulse <= 1'b0;
        end
        chk32("count end", 32'h0, countValue);
        chk32("terminal pulses", 32'h1, tcs);
        chk1("gate at zero", 1'b0, tckGate);
        countEn <= 1'b0;
        load(32'h01000000);
        singleStepBit <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk32("step", 32'h00ffffff, countValue);
        chk1("gate in step", 1'b0, tckGate);
        singleStepBit <= 1'b0;
        load(32'h0);
        singleStepBit <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk32("step at zero", 32'h0, countValue);
        singleStepBit <= 1'b0;
        load(32'h55);
        rstPinN <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rstPinN <= 1'b1;
        chk32("pin clear", 32'h0, countValue);
        load(32'haa);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        chk32("count after nrst", CNT_RESET, countValue);
        chk1("irq after nrst", 1'b0, irq);
        end_sim();
    end
endmodule
